// ===== src/swdk_defs.svh
// swdk_defs.svh: register map, field positions, key values and counts
// assumes: included by bare name from the key and info block and its package
`ifndef SWDK_DEFS_SVH
`define SWDK_DEFS_SVH

`define SWDK_OFS_CTRL        12'h000
`define SWDK_OFS_KEY_STATUS  12'h004
`define SWDK_OFS_SYS_STATUS  12'h008
`define SWDK_OFS_BOOT_CHECK  12'h00C

`define SWDK_CTRL_GAP_BIT    0
`define SWDK_KEY_ERASE_BIT   0
`define SWDK_KEY_PROG_BIT    1
`define SWDK_KEY_UROW_BIT    2
`define SWDK_SYS_LOCK_BIT    0
`define SWDK_SYS_PRDY_BIT    1
`define SWDK_SYS_URDY_BIT    2
`define SWDK_SYS_ERASE_BIT   3

`define SWDK_KEY_ERASE       64'h4E564D4572617365
`define SWDK_KEY_PROG        64'h4E564D50726F6720
`define SWDK_KEY_UROW        64'h4E564D5573267465

`define SWDK_SIZE_8          2'h0
`define SWDK_SIZE_16         2'h1
`define SWDK_FRAMES_8        5'h08
`define SWDK_FRAMES_16       5'h10
`define SWDK_GAP_BITS        2'h2

`endif

// ===== src/swdk_pkg.sv
// swdk_pkg: types shared by the key and info block and its bench
// assumes: swdk_defs.svh is on the include path
package swdk_pkg;
  `include "swdk_defs.svh"

  typedef enum logic [4:0] {
    SWDK_IDLE  = 5'b00001,
    SWDK_KEYRX = 5'b00010,
    SWDK_GUARD = 5'b00100,
    SWDK_SEND  = 5'b01000,
    SWDK_GAP   = 5'b10000
  } swdk_state_t;

  // one decoded key instruction from the link layer
  typedef struct packed {
    logic       start;
    logic       info_sel;
    logic [1:0] size;
  } swdk_cmd_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } swdk_apb_req_t;
endpackage : swdk_pkg

// ===== src/swdk_key_info.sv
// swdk_key_info: key activation, system info readout and key gating for
// the single_wire_debug_port data-link layer, with an APB register file
// assumes: link byte strobes, bit ticks and status flags come from logic
// on clk_sys_i; only the sync_character pin is asynchronous
//
// Behaviour
// - key instruction accepts only full 64-bit keys; other sizes never match
// - info readout returns at most 128 bits
// - size operand sets frames received for key or sent for info block
// - no acknowledge or response is sent after a key
// - first info byte waits for the configured guard time
// - boot_check_result is readable from a register even when locked
// - multi-byte output bytes go back to back without guard time
// - gap enable inserts exactly two idle bit periods between bytes
// - info block is served at any time regardless of lock state
// - size 16 returns whole block, size 8 returns bytes 0 to 7
// - block bytes: family text, revisions, oscillator, reserved 7 and 14
// - three 64-bit keys recognised, least significant byte first
// - erase key starts erase, clears lock, dropped on disable or reset
// - programming needs lock clear and ready flag; dropped when done
// - user row needs lock set and ready flag; dropped by status write
// - level event for each rising edge of received sync character
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps

// the guard keeps this harmless when the package already pulled it in
`include "swdk_defs.svh"

module swdk_key_info
  import swdk_pkg::*;
#(
  // arbitrary neutral identification text, not of any real part
  parameter logic [55:0] FAMILY_TEXT  = 56'h3130_5954_4E45_44,
  parameter logic [23:0] MEM_REVISION = 24'h30_302E,
  parameter logic [23:0] DBG_REVISION = 24'h30_302E,
  parameter logic [7:0]  OSC_FREQ     = 8'h33
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire swdk_apb_req_t apb_i,
  output logic               pready_o,
  output logic        [31:0] prdata_o,
  output logic               pslverr_o,
  input  wire swdk_cmd_t     key_cmd_i,
  input  wire logic          rx_valid_i,
  input  wire logic    [7:0] rx_data_i,
  input  wire logic          bit_tick_i,
  input  wire logic    [7:0] guard_bits_i,
  input  wire logic          tx_ready_i,
  output logic               tx_valid_o,
  output logic         [7:0] tx_data_o,
  output logic               tx_busy_o,
  input  wire logic          port_disable_i,
  input  wire logic          lock_bits_i,
  input  wire logic          prog_ready_flag_i,
  input  wire logic          user_row_ready_flag_i,
  input  wire logic          programming_done_i,
  input  wire logic    [7:0] boot_check_result_i,
  input  wire logic          sync_pin_i,
  input  wire logic          sync_window_i,
  output logic               sync_event_o,
  output logic               chip_erase_start_o,
  output logic               lock_clear_o,
  output logic               mem_prog_enable_o,
  output logic               user_row_enable_o
);

  localparam logic [127:0] INFO_BLOCK = {OSC_FREQ, 8'h00, DBG_REVISION,
                                         MEM_REVISION, 8'h00, FAMILY_TEXT};

  function automatic logic [7:0] info_byte(input logic [3:0] idx);
    info_byte = INFO_BLOCK[{idx, 3'h0} +: 8];
  endfunction : info_byte

  function automatic logic [4:0] frames_of(input logic [1:0] size);
    frames_of = (size == `SWDK_SIZE_16) ? `SWDK_FRAMES_16 : `SWDK_FRAMES_8;
  endfunction : frames_of

  swdk_state_t state_q;
  logic  [4:0] frames_q;
  logic  [4:0] count_q;
  logic  [7:0] wait_q;
  logic [63:0] key_shift_q;
  logic        key_check_q;
  logic        gap_enable_q;
  logic        erase_key_q;
  logic        prog_key_q;
  logic        urow_key_q;
  logic        sync_meta_q;
  logic        sync_q;

  wire logic apb_access = apb_i.psel && apb_i.penable;
  wire logic apb_write  = apb_access && pready_o && apb_i.pwrite;
  wire logic addr_hit   = (apb_i.paddr == `SWDK_OFS_CTRL) ||
                          (apb_i.paddr == `SWDK_OFS_KEY_STATUS) ||
                          (apb_i.paddr == `SWDK_OFS_SYS_STATUS) ||
                          (apb_i.paddr == `SWDK_OFS_BOOT_CHECK);
  wire logic last_byte  = (count_q == frames_q - 5'h01);
  wire logic tx_take    = tx_valid_o && tx_ready_i;
  wire logic key_done   = (state_q == SWDK_KEYRX) && rx_valid_i && last_byte;
  wire logic key_len_ok = (frames_q == `SWDK_FRAMES_8);
  wire logic urow_clear = apb_write &&
                          (apb_i.paddr == `SWDK_OFS_KEY_STATUS) &&
                          apb_i.pwdata[`SWDK_KEY_UROW_BIT];

  // one wait state: pready is high in the second access cycle, then drops
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= apb_access && !pready_o;
      pslverr_o <= apb_access && !pready_o && !addr_hit;
      if (apb_access && !pready_o) begin
        case (apb_i.paddr)
          `SWDK_OFS_CTRL:       prdata_o <= {31'h0, gap_enable_q};
          `SWDK_OFS_KEY_STATUS: prdata_o <= {29'h0, urow_key_q, prog_key_q,
                                             erase_key_q};
          `SWDK_OFS_SYS_STATUS: prdata_o <= {28'h0, erase_key_q,
                                             user_row_ready_flag_i,
                                             prog_ready_flag_i, lock_bits_i};
          `SWDK_OFS_BOOT_CHECK: prdata_o <= {24'h0, boot_check_result_i};
          default:              prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gap_enable_q <= 1'b0;
    end else if (apb_write && apb_i.paddr == `SWDK_OFS_CTRL) begin
      gap_enable_q <= apb_i.pwdata[`SWDK_CTRL_GAP_BIT];
    end
  end

  // key bytes arrive low byte first, so each new byte enters at the top
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      key_shift_q <= 64'h0;
      key_check_q <= 1'b0;
    end else begin
      if (state_q == SWDK_KEYRX && rx_valid_i) begin
        key_shift_q <= {rx_data_i, key_shift_q[63:8]};
      end
      key_check_q <= key_done && key_len_ok;
    end
  end

  // match pulses are evaluated one cycle after the last byte
  wire logic hit_erase = key_check_q && key_shift_q == `SWDK_KEY_ERASE;
  wire logic hit_prog  = key_check_q && key_shift_q == `SWDK_KEY_PROG;
  wire logic hit_urow  = key_check_q && key_shift_q == `SWDK_KEY_UROW;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      erase_key_q <= 1'b0;
      prog_key_q  <= 1'b0;
      urow_key_q  <= 1'b0;
    end else begin
      if (hit_erase) begin
        erase_key_q <= 1'b1;
      end else if (port_disable_i) begin
        erase_key_q <= 1'b0;
      end
      if (hit_prog) begin
        prog_key_q <= 1'b1;
      end else if (programming_done_i) begin
        prog_key_q <= 1'b0;
      end
      // a fresh key wins over a clear in the same cycle
      if (hit_urow) begin
        urow_key_q <= 1'b1;
      end else if (urow_clear) begin
        urow_key_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      chip_erase_start_o <= 1'b0;
      lock_clear_o       <= 1'b0;
      mem_prog_enable_o  <= 1'b0;
      user_row_enable_o  <= 1'b0;
    end else begin
      chip_erase_start_o <= hit_erase;
      lock_clear_o       <= hit_erase;
      mem_prog_enable_o  <= prog_key_q && !lock_bits_i &&
                            prog_ready_flag_i;
      user_row_enable_o  <= urow_key_q && lock_bits_i &&
                            user_row_ready_flag_i;
    end
  end

  // no state leads from a finished key to the transmitter
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q  <= SWDK_IDLE;
      frames_q <= `SWDK_FRAMES_8;
      count_q  <= 5'h00;
      wait_q   <= 8'h00;
    end else begin
      case (state_q)
        SWDK_IDLE: begin
          count_q <= 5'h00;
          if (key_cmd_i.start) begin
            frames_q <= frames_of(key_cmd_i.size);
            wait_q   <= guard_bits_i;
            // info select ignores the lock state entirely
            state_q  <= key_cmd_i.info_sel ? SWDK_GUARD : SWDK_KEYRX;
          end
        end
        SWDK_KEYRX: begin
          if (rx_valid_i) begin
            count_q <= count_q + 5'h01;
            if (last_byte) begin
              state_q <= SWDK_IDLE;
            end
          end
        end
        SWDK_GUARD: begin
          if (wait_q == 8'h00) begin
            state_q <= SWDK_SEND;
          end else if (bit_tick_i) begin
            wait_q <= wait_q - 8'h01;
          end
        end
        SWDK_SEND: begin
          if (tx_take) begin
            count_q <= count_q + 5'h01;
            wait_q  <= {6'h00, `SWDK_GAP_BITS};
            if (last_byte) begin
              state_q <= SWDK_IDLE;
            end else if (gap_enable_q) begin
              state_q <= SWDK_GAP;
            end
          end
        end
        SWDK_GAP: begin
          if (bit_tick_i) begin
            wait_q <= wait_q - 8'h01;
            if (wait_q == 8'h01) begin
              state_q <= SWDK_SEND;
            end
          end
        end
        default: state_q <= SWDK_IDLE;
      endcase
    end
  end

  // without gap enable, the next byte is offered two cycles after the previous is taken, after one idle cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_busy_o  <= 1'b0;
    end else begin
      tx_busy_o <= (state_q == SWDK_GUARD) || (state_q == SWDK_SEND) ||
                   (state_q == SWDK_GAP);
      if (tx_take) begin
        tx_valid_o <= 1'b0;
      end else if (state_q == SWDK_SEND && !tx_valid_o) begin
        tx_valid_o <= 1'b1;
        tx_data_o  <= info_byte(count_q[3:0]);
      end
    end
  end

  // the event follows the synchronised pin level, gated only by the
  // link's own sync window; software has no way to mask it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_meta_q  <= 1'b0;
      sync_q       <= 1'b0;
      sync_event_o <= 1'b0;
    end else begin
      sync_meta_q  <= sync_pin_i;
      sync_q       <= sync_meta_q;
      sync_event_o <= sync_q && sync_window_i;
    end
  end

endmodule : swdk_key_info

// ===== bench/swdk_key_info_monitor.sv
// swdk_key_info_monitor: port-level assertions for swdk_key_info
// assumes: bound to the design, one clock, reset active high
`timescale 1ns/100ps
module swdk_key_info_monitor
  import swdk_pkg::*;
(
  input wire logic          clk_sys_i,
  input wire logic          rst_i,
  input wire swdk_apb_req_t apb_i,
  input wire logic          pready_o,
  input wire swdk_cmd_t     key_cmd_i,
  input wire logic          tx_ready_i,
  input wire logic          tx_valid_o,
  input wire logic    [7:0] tx_data_o,
  input wire logic          tx_busy_o,
  input wire logic          lock_bits_i,
  input wire logic          prog_ready_flag_i,
  input wire logic          user_row_ready_flag_i,
  input wire logic          sync_window_i,
  input wire logic          sync_event_o,
  input wire logic          chip_erase_start_o,
  input wire logic          lock_clear_o,
  input wire logic          mem_prog_enable_o,
  input wire logic          user_row_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_setup;
    apb_i.psel && !apb_i.penable;
  endsequence
  sequence s_key_go;
    key_cmd_i.start && !key_cmd_i.info_sel && !tx_busy_o;
  endsequence
  apb_wait_a: assert property (s_setup |-> ##2 pready_o)
    else $error("register answer late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("register answer longer than one cycle");
  key_silent_a: assert property (s_key_go |=> (!tx_valid_o) [*8])
    else $error("byte sent after a key");
  erase_pair_a: assert property (
    chip_erase_start_o |-> lock_clear_o ##1 !chip_erase_start_o)
    else $error("erase start without lock clear");
  prog_gate_a: assert property (
    mem_prog_enable_o |-> !$past(lock_bits_i) && $past(prog_ready_flag_i))
    else $error("programming enabled while not allowed");
  urow_gate_a: assert property (
    user_row_enable_o |-> $past(lock_bits_i) && $past(user_row_ready_flag_i))
    else $error("user row enabled while not allowed");
  tx_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("offered byte dropped or changed");
  sync_gate_a: assert property (sync_event_o |-> $past(sync_window_i))
    else $error("sync event outside sync character");
endmodule : swdk_key_info_monitor

bind swdk_key_info swdk_key_info_monitor u_mon (
  .clk_sys_i, .rst_i, .apb_i, .pready_o, .key_cmd_i, .tx_ready_i,
  .tx_valid_o, .tx_data_o, .tx_busy_o, .lock_bits_i, .prog_ready_flag_i,
  .user_row_ready_flag_i, .sync_window_i, .sync_event_o,
  .chip_erase_start_o, .lock_clear_o, .mem_prog_enable_o, .user_row_enable_o
);

// ===== bench/swdk_link_host.sv
// swdk_link_host: programmer model on the single wire link
// assumes: bench calls send_key and reads got_q and gap_q
`timescale 1ns/100ps
module swdk_link_host (
  input  wire logic       clk_sys_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            bit_tick_o,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o
);
  int         div = 0;
  int         cyc = 0;
  int         last = 0;
  logic [7:0] got_q[$];
  int         gap_q[$];
  initial begin
    bit_tick_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5A;
  end
  // slow mode takes a byte only on bit ticks
  assign tx_ready_o = slow_i ? bit_tick_o : 1'b1;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    div <= (div == 3) ? 0 : div + 1;
    bit_tick_o <= (div == 3);
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
      gap_q.push_back(cyc - last);
      last <= cyc;
    end
  end
  // low byte first; idle data line shows the inverse so it never looks held
  task automatic send_key(input logic [63:0] k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= k[8*(i%8)+:8];
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~k[8*(i%8)+:8];
    end
  endtask : send_key
endmodule : swdk_link_host

// ===== bench/swdk_key_info_test.sv
// swdk_key_info_test: self-checking bench for swdk_key_info
// assumes: swdk_link_host stands for the programmer on the link
`timescale 1ns/100ps
module swdk_key_info_test
  import swdk_pkg::*;
;
  localparam logic [55:0]  FAM = 56'h3130_5954_4E45_44;
  localparam logic [23:0]  MR  = 24'h31_302E;
  localparam logic [23:0]  DR  = 24'h32_302E;
  localparam logic [127:0] SYSTEM_INFO_BLOCK = {8'h33, 8'h00, DR, MR, 8'h00, FAM};
  localparam logic [63:0]  KE  = 64'h4E564D4572617365;
  logic          clk_sys_i = 1'b0, rst_i = 1'b1, slow_i = 1'b0, err;
  swdk_apb_req_t apb_i = '0;
  swdk_cmd_t     key_cmd_i = '0;
  logic [7:0]    guard_bits_i = '0, boot_check_result_i = '0, tx_data_o;
  logic [7:0]    rx_data_i;
  logic [31:0]   prdata_o, rd;
  logic          port_disable_i = 0, lock_bits_i = 1, prog_ready_flag_i = 0;
  logic          user_row_ready_flag_i = 0, programming_done_i = 0;
  logic          sync_pin_i = 0, sync_window_i = 0, bit_tick_i, tx_ready_i;
  logic          rx_valid_i, pready_o, pslverr_o, tx_valid_o, tx_busy_o;
  logic          sync_event_o, chip_erase_start_o, lock_clear_o;
  logic          mem_prog_enable_o, user_row_enable_o;
  int            errors = 0, checks_done = 0, seed = 76, ers = 0, kst = 0;
  int            gap_on = 0;
  swdk_key_info #(.FAMILY_TEXT(FAM), .MEM_REVISION(MR), .DBG_REVISION(DR),
    .OSC_FREQ(8'h33)) u_dut (.clk_sys_i, .rst_i, .apb_i, .pready_o,
    .prdata_o, .pslverr_o, .key_cmd_i, .rx_valid_i, .rx_data_i, .bit_tick_i,
    .guard_bits_i, .tx_ready_i, .tx_valid_o, .tx_data_o, .tx_busy_o,
    .port_disable_i, .lock_bits_i, .prog_ready_flag_i, .user_row_ready_flag_i,
    .programming_done_i, .boot_check_result_i, .sync_pin_i, .sync_window_i,
    .sync_event_o, .chip_erase_start_o, .lock_clear_o, .mem_prog_enable_o,
    .user_row_enable_o);
  swdk_link_host u_host (.clk_sys_i, .slow_i, .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .bit_tick_o(bit_tick_i), .tx_ready_o(tx_ready_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) ers <= ers + chip_erase_start_o;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clk_sys_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    apb_i <= '0;
  endtask : apb
  task automatic start(input logic sel, input logic [1:0] sz);
    @(posedge clk_sys_i);
    key_cmd_i <= '{1'b1, sel, sz};
    @(posedge clk_sys_i);
    key_cmd_i.start <= 1'b0;
  endtask : start
  task automatic info(input logic [1:0] sz, input int cnt);
    int g, t, sp;
    g = $random(seed) & 3;
    guard_bits_i <= 8'(g);
    u_host.got_q.delete();
    u_host.gap_q.delete();
    start(1'b1, sz);
    t = 0;
    do begin @(posedge clk_sys_i); t += bit_tick_i; end while (!tx_valid_o);
    check(t >= g, 1);
    check(tx_busy_o, 1);
    repeat (300) @(posedge clk_sys_i);
    check(tx_busy_o, 0);
    check(u_host.got_q.size(), cnt);
    for (int i = 0; i < u_host.got_q.size(); i++) begin
      check(u_host.got_q[i], SYSTEM_INFO_BLOCK[8*i+:8]);
      sp = u_host.gap_q[i];
      if (i > 0 && !slow_i) check(gap_on ? sp > 4 && sp < 14 : sp <= 2, 1);
    end
  endtask : info
  task automatic key(input logic [63:0] k, input logic [1:0] sz, input int n);
    start(1'b0, sz);
    u_host.send_key(k, n);
    repeat (4) @(posedge clk_sys_i);
    apb(0, 12'h004, 0);
    check(rd, kst);
  endtask : key
  task automatic give_verdict;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    boot_check_result_i <= 8'($random(seed));
    apb(0, 12'h00C, 0);
    check(rd, {24'h0, boot_check_result_i});
    apb(0, 12'h010, 0);
    check({err, rd[30:0]}, 32'h8000_0000);
    info(2'h1, 16);
    apb(1, 12'h000, 1);
    gap_on = 1;
    info(2'h0, 8);
    slow_i <= 1'b1;
    info(2'h1, 16);
    slow_i <= 1'b0;
    key({$random(seed), $random(seed)}, 0, 8);
    key(KE, 1, 16);
    kst = 1;
    key(KE, 0, 8);
    check(ers, 1);
    port_disable_i <= 1'b1;
    kst = 0;
    key(64'h0, 0, 8);
    port_disable_i <= 1'b0;
    {lock_bits_i, prog_ready_flag_i} <= 2'b01;
    kst = 2;
    key(64'h4E564D50726F6720, 0, 8);
    check(mem_prog_enable_o, 1);
    programming_done_i <= 1'b1;
    @(posedge clk_sys_i);
    programming_done_i <= 1'b0;
    kst = 0;
    key(64'h0, 0, 8);
    check(mem_prog_enable_o, 0);
    {lock_bits_i, user_row_ready_flag_i} <= 2'b11;
    kst = 4;
    key(64'h4E564D5573267465, 0, 8);
    check(user_row_enable_o, 1);
    apb(0, 12'h008, 0);
    check(rd, 32'h0000_0007);
    apb(1, 12'h004, 4);
    repeat (2) @(posedge clk_sys_i);
    check(user_row_enable_o, 0);
    {sync_pin_i, sync_window_i} <= 2'b11;
    repeat (5) @(posedge clk_sys_i);
    check(sync_event_o, 1);
    sync_pin_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    check(sync_event_o, 0);
    sync_pin_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check(sync_event_o, 1);
    sync_pin_i <= 1'b0;
    kst = 1;
    key(KE, 0, 8);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(0, 12'h000, 0);
    check(rd, 0);
    kst = 0;
    key(64'h0, 0, 8);
    give_verdict();
  end
endmodule : swdk_key_info_test
